// [pkg/amc_params.svh]
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

// Register byte offsets (low address byte only is decoded).
`define AMC_ADDR_CTRL      8'h00
`define AMC_ADDR_STATUS    8'h04
`define AMC_ADDR_RESULT    8'h08
`define AMC_ADDR_INTSTAT   8'h0C
`define AMC_ADDR_INTMASK   8'h10

// Control register field and reset value.
`define AMC_CTRL_INTCLK    0
`define AMC_CTRL_RESET     1'h1

// Control byte fields, start bit is bit 7.
`define AMC_BYTE_POL       6
`define AMC_BYTE_MH        1
`define AMC_BYTE_ML        0

// Mode bit pairs {high, low}.
`define AMC_MODE_SHORT     2'h0
`define AMC_MODE_CAL       2'h1
`define AMC_MODE_PD        2'h2
`define AMC_MODE_LONG      2'h3

// Acquisition and conversion lengths in conversion clock cycles.
`define AMC_SHORT_ACQ      6'h05
`define AMC_SHORT_TOTAL    6'h18
`define AMC_LONG_ACQ       6'h0D
`define AMC_LONG_TOTAL     6'h20

// Calibration length in conversion clock cycles.
`define AMC_CAL_CYCLES     80000

// Internal conversion clock divider from ref_clk.
`define AMC_INT_DIV        4'h2

// Interrupt status bit positions.
`define AMC_INT_CONV       0
`define AMC_INT_CALDONE    1
`define AMC_INT_CALABORT   2
`define AMC_INT_POWER_DOWN_PIN_N       3

// Synchroniser reset: the reset and power-down pins rest high, chip select rests low.
`define AMC_SYNC_RESET     5'h03

`endif

// [pkg/amc_pkg.sv]
`default_nettype none
package amc_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ACQ,
      ST_CONV,
      ST_CAL,
      ST_POWER_DOWN_PIN_N
   } amc_state_t;

   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
   } amc_sync_t;

   typedef struct packed {
      amc_state_t  st;
      logic        sclkPrev;
      logic        shifting;
      logic [2:0]  bitCnt;
      logic [5:0]  shiftReg;
      logic        longAcq;
      logic        polaritySelect;
      logic        pdAfter;
      logic        hwDown;
      logic [5:0]  convCnt;
      logic [16:0] calCnt;
      logic [3:0]  divCnt;
      logic [15:0] sample;
      logic [15:0] result;
      logic        strobe;
      logic        lowPower;
      logic        ctrlInternal;
      logic [3:0]  intStat;
      logic [3:0]  intMask;
      logic        irq;
      logic        wrPend;
      logic [7:0]  wrAddr;
      logic [31:0] hrdata;
      logic        hready;
      logic        hresp;
   } amc_ctrl_t;

endpackage
`default_nettype wire

// [hdl/amc_sync.sv]
`default_nettype none
`include "amc_params.svh"
module amc_sync
   import amc_pkg::*;
(
   // Clock and reset.
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // Pins in and synchronised copies out.
   input  wire logic [4:0] pinIn,
   output logic [4:0]      pinOut
);

   amc_sync_t r;
   amc_sync_t n;

   // The first stage feeds only the second stage.
   always_comb begin
      n = r;
      n.s1 = pinIn;
      n.s2 = r.s1;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         r.s1 <= `AMC_SYNC_RESET;
         r.s2 <= `AMC_SYNC_RESET;
      end else begin
         r <= n;
      end
   end

   assign pinOut = r.s2;

endmodule
`default_nettype wire

// [hdl/amc_ctrl.sv]
`default_nettype none
`include "amc_params.svh"
module amc_ctrl
   import amc_pkg::*;
#(
   parameter int CAL_CYCLES = `AMC_CAL_CYCLES
) (
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Serial and control pins.
   input  wire logic        sclkPin,
   input  wire logic        dinPin,
   input  wire logic        csPinN,
   input  wire logic        rstPinN,
   input  wire logic        powerDownPinN,
   // Converter core sample, offset binary.
   input  wire logic [15:0] rawSample,
   // Status outputs.
   output logic             conversionStrobeOut,
   output logic [15:0]      resultWord,
   output logic             lowPowerOut,
   output logic             irq
);

   localparam logic [16:0] CAL_LAST = 17'(CAL_CYCLES - 1);

   amc_ctrl_t   r;
   amc_ctrl_t   n;
   logic [4:0]  pinS;
   logic        sclkSync;
   logic        dinSync;
   logic        csSyncN;
   logic        rstSyncN;
   logic        pdSyncN;
   logic        sclkRise;
   logic        tickNow;
   logic        listenState;
   logic        startNow;
   logic        byteDone;
   logic [7:0]  ctrlByte;
   logic [1:0]  modeBits;
   logic [5:0]  acqLast;
   logic [5:0]  totalLast;
   logic        convEnd;
   logic        pinsQuiet;
   logic        apTake;
   logic [15:0] formatted;

   amc_sync u_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pinIn   ({sclkPin, dinPin, csPinN, rstPinN, powerDownPinN}),
      .pinOut  (pinS)
   );

   assign sclkSync    = pinS[4];
   assign dinSync     = pinS[3];
   assign csSyncN     = pinS[2];
   assign rstSyncN    = pinS[1];
   assign pdSyncN     = pinS[0];

   // External clock mode counts serial clock edges, so cycles only advance while the host clocks.
   assign sclkRise    = sclkSync & ~r.sclkPrev;
   assign tickNow     = r.ctrlInternal ? (r.divCnt == (`AMC_INT_DIV - 4'h1)) : sclkRise;
   assign listenState = (r.st == ST_IDLE) | (r.st == ST_POWER_DOWN_PIN_N) | (r.st == ST_CAL);
   assign startNow    = sclkRise & ~csSyncN & dinSync & ~r.shifting & listenState;
   assign byteDone    = sclkRise & ~csSyncN & r.shifting & (r.bitCnt == 3'h6);
   assign ctrlByte    = {1'b1, r.shiftReg, dinSync};
   assign modeBits    = {ctrlByte[`AMC_BYTE_MH], ctrlByte[`AMC_BYTE_ML]};
   assign acqLast     = r.longAcq ? (`AMC_LONG_ACQ - 6'h01) : (`AMC_SHORT_ACQ - 6'h01);
   assign totalLast   = r.longAcq ? (`AMC_LONG_TOTAL - 6'h01) : (`AMC_SHORT_TOTAL - 6'h01);
   assign convEnd     = (r.st == ST_CONV) & tickNow & (r.convCnt == totalLast);
   assign pinsQuiet   = rstSyncN & pdSyncN;
   assign apTake      = hsel & hready & htrans[1];
   // The core delivers offset binary; flipping the sign bit gives two's complement.
   assign formatted   = r.polaritySelect ? r.sample : {~r.sample[15], r.sample[14:0]};

   always_comb begin
      logic [3:0] ev;
      logic [3:0] clr;
      ev = 4'h0;
      clr = 4'h0;
      n = r;
      n.sclkPrev = sclkSync;
      if (r.ctrlInternal && !tickNow) begin
         n.divCnt = r.divCnt + 4'h1;
      end else begin
         n.divCnt = 4'h0;
      end

      if (csSyncN) begin
         n.shifting = 1'b0;
      end else if (startNow) begin
         n.shifting = 1'b1;
         n.bitCnt = 3'h0;
      end else if (sclkRise && r.shifting) begin
         n.shiftReg = {r.shiftReg[4:0], dinSync};
         n.bitCnt = r.bitCnt + 3'h1;
         if (byteDone) begin
            n.shifting = 1'b0;
         end
      end

      case (r.st)
         ST_IDLE: begin
         end
         ST_POWER_DOWN_PIN_N: begin
            if (startNow) begin
               n.st = ST_IDLE;
            end
         end
         ST_CAL: begin
            if (startNow) begin
               n.st = ST_IDLE;
               ev[`AMC_INT_CALABORT] = 1'b1;
            end else if (tickNow) begin
               if (r.calCnt == CAL_LAST) begin
                  n.st = ST_IDLE;
                  ev[`AMC_INT_CALDONE] = 1'b1;
               end else begin
                  n.calCnt = r.calCnt + 17'h00001;
               end
            end
         end
         ST_ACQ: begin
            if (tickNow) begin
               n.convCnt = r.convCnt + 6'h01;
               if (r.convCnt == acqLast) begin
                  n.sample = rawSample;
                  n.st = ST_CONV;
               end
            end
         end
         ST_CONV: begin
            if (convEnd) begin
               n.result = formatted;
               ev[`AMC_INT_CONV] = 1'b1;
               if (r.pdAfter) begin
                  n.st = ST_POWER_DOWN_PIN_N;
                  ev[`AMC_INT_POWER_DOWN_PIN_N] = 1'b1;
               end else begin
                  n.st = ST_IDLE;
               end
            end else if (tickNow) begin
               n.convCnt = r.convCnt + 6'h01;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase

      // A byte is only decoded from idle; a start bit in shutdown or calibration leads here.
      if (byteDone && r.st == ST_IDLE) begin
         n.polaritySelect = ctrlByte[`AMC_BYTE_POL];
         n.convCnt = 6'h00;
         n.divCnt = 4'h0;
         case (modeBits)
            `AMC_MODE_CAL: begin
               n.st = ST_CAL;
               n.calCnt = 17'h00000;
            end
            `AMC_MODE_SHORT: begin
               n.longAcq = 1'b0;
               n.pdAfter = 1'b0;
               n.st = ST_ACQ;
            end
            `AMC_MODE_LONG: begin
               n.longAcq = 1'b1;
               n.pdAfter = 1'b0;
               n.st = ST_ACQ;
            end
            `AMC_MODE_PD: begin
               n.pdAfter = 1'b1;
               n.st = ST_ACQ;
            end
            default: begin
               n.st = ST_IDLE;
            end
         endcase
      end

      // Pins override the state machine; a conversion cut by them before its last tick delivers no result.
      if (!rstSyncN) begin
         if (r.st == ST_CAL) begin
            ev[`AMC_INT_CALABORT] = 1'b1;
         end
         n.st = ST_IDLE;
         n.shifting = 1'b0;
         n.hwDown = 1'b0;
      end else if (!pdSyncN) begin
         if (r.st == ST_CAL) begin
            ev[`AMC_INT_CALABORT] = 1'b1;
         end
         if (r.st != ST_POWER_DOWN_PIN_N) begin
            ev[`AMC_INT_POWER_DOWN_PIN_N] = 1'b1;
         end
         n.st = ST_POWER_DOWN_PIN_N;
         n.shifting = 1'b0;
         n.hwDown = 1'b1;
      end else if (r.hwDown) begin
         n.hwDown = 1'b0;
         n.st = ST_IDLE;
      end

      n.lowPower = (n.st == ST_POWER_DOWN_PIN_N);

      n.hready = 1'b1;
      n.hresp = 1'b0;
      if (r.wrPend) begin
         case (r.wrAddr)
            `AMC_ADDR_CTRL: begin
               n.ctrlInternal = hwdata[`AMC_CTRL_INTCLK];
            end
            `AMC_ADDR_INTMASK: begin
               n.intMask = hwdata[3:0];
            end
            `AMC_ADDR_INTSTAT: begin
               clr = hwdata[3:0];
            end
            default: begin
            end
         endcase
      end
      // The strobe follows a clock mode write at once, so it never lags the mode by a cycle.
      n.strobe = n.ctrlInternal ? !((n.st == ST_CAL) || (n.st == ST_ACQ) || (n.st == ST_CONV))
                                : (n.st == ST_CAL);
      // A new event wins over a clear in the same cycle.
      n.intStat = (r.intStat & ~clr) | ev;
      n.irq = |(n.intStat & n.intMask);
      n.wrPend = apTake & hwrite;
      n.wrAddr = haddr[7:0];
      if (apTake && !hwrite) begin
         case (haddr[7:0])
            `AMC_ADDR_CTRL: n.hrdata = {31'h00000000, n.ctrlInternal};
            `AMC_ADDR_STATUS: n.hrdata = {25'h0000000, n.hwDown, n.pdAfter, n.polaritySelect,
                                          n.longAcq, n.st};
            `AMC_ADDR_RESULT: n.hrdata = {16'h0000, n.result};
            `AMC_ADDR_INTSTAT: n.hrdata = {28'h0000000, n.intStat};
            `AMC_ADDR_INTMASK: n.hrdata = {28'h0000000, n.intMask};
            default: n.hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.ctrlInternal <= `AMC_CTRL_RESET;
         r.strobe <= 1'b1;
         r.hready <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign hrdata              = r.hrdata;
   assign hreadyout           = r.hready;
   assign hresp               = r.hresp;
   assign conversionStrobeOut = r.strobe;
   assign resultWord          = r.result;
   assign lowPowerOut         = r.lowPower;
   assign irq                 = r.irq;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   property p_calStart;
      (byteDone && r.st == ST_IDLE && modeBits == `AMC_MODE_CAL && pinsQuiet)
         |=> (r.st == ST_CAL) && (r.calCnt == 17'h00000);
   endproperty
   a_calStart: assert property (p_calStart)
      else $error("Calibration command did not start a fresh calibration.");

   property p_calEnd;
      (r.st == ST_CAL && tickNow && r.calCnt == CAL_LAST && pinsQuiet && !startNow)
         |=> (r.st == ST_IDLE) && r.intStat[`AMC_INT_CALDONE];
   endproperty
   a_calEnd: assert property (p_calEnd)
      else $error("Calibration did not end after its full count.");

   property p_calAbort;
      (r.st == ST_CAL && (!rstSyncN || !pdSyncN || startNow))
         |=> (r.st != ST_CAL) && r.intStat[`AMC_INT_CALABORT];
   endproperty
   a_calAbort: assert property (p_calAbort)
      else $error("Calibration was not aborted.");

   property p_pdAfterConv;
      (convEnd && r.pdAfter && pinsQuiet) |=> (r.st == ST_POWER_DOWN_PIN_N) && lowPowerOut
         && (resultWord == $past(formatted));
   endproperty
   a_pdAfterConv: assert property (p_pdAfterConv)
      else $error("Software power-down did not follow the finished conversion.");

   property p_wake;
      (r.st == ST_POWER_DOWN_PIN_N && startNow && pinsQuiet)
         |=> (r.st == ST_IDLE) ##7 ((r.st != ST_POWER_DOWN_PIN_N) || r.hwDown);
   endproperty
   a_wake: assert property (p_wake)
      else $error("Start bit did not wake the device from shutdown.");

   property p_keepAcq;
      (byteDone && r.st == ST_IDLE && modeBits == `AMC_MODE_PD && pinsQuiet)
         |=> (r.longAcq == $past(r.longAcq)) && r.pdAfter && (r.st == ST_ACQ);
   endproperty
   a_keepAcq: assert property (p_keepAcq)
      else $error("Power-down conversion changed the acquisition length.");

   property p_hwDown;
      (!pdSyncN && rstSyncN) |=> (r.st == ST_POWER_DOWN_PIN_N) && lowPowerOut;
   endproperty
   a_hwDown: assert property (p_hwDown)
      else $error("Shutdown pin did not force shutdown.");

   property p_acqLen;
      (r.st == ST_ACQ && tickNow && r.convCnt == acqLast && pinsQuiet)
         |=> (r.st == ST_CONV) && (r.convCnt == (r.longAcq ? 6'h0D : 6'h05));
   endproperty
   a_acqLen: assert property (p_acqLen)
      else $error("Acquisition length is wrong.");

   property p_convLen;
      (r.st == ST_CONV && tickNow && pinsQuiet && r.convCnt != totalLast)
         |=> (r.st == ST_CONV);
   endproperty
   a_convLen: assert property (p_convLen)
      else $error("Conversion ended before its full length.");

   property p_strobeCal;
      (r.st == ST_CAL) |-> (conversionStrobeOut == !r.ctrlInternal);
   endproperty
   a_strobeCal: assert property (p_strobeCal)
      else $error("Strobe level wrong during calibration.");

   c_calDone: cover property (r.st == ST_CAL ##1 r.st == ST_IDLE && r.intStat[`AMC_INT_CALDONE]);
   c_calStartAbort: cover property (r.st == ST_CAL && startNow);
   c_swWake: cover property (r.st == ST_POWER_DOWN_PIN_N && !r.hwDown && startNow);
   c_longConv: cover property (convEnd && r.longAcq);

endmodule
`default_nettype wire

// [tb/amc_host_model.sv]
`default_nettype none
module amc_host_model (
   // Clock.
   input  wire logic ref_clk,
   // Serial pins toward the converter.
   output logic      sclkPin,
   output logic      dinPin,
   output logic      csPinN
);
   timeunit 1ns;
   timeprecision 1ns;

   // The serial clock stands low between frames.
   initial begin
      sclkPin = 1'b0;
      dinPin  = 1'b0;
      csPinN  = 1'b1;
   end

   // Half periods of four reference cycles give the pin synchronisers room.
   task automatic half(input logic s);
      sclkPin <= s;
      repeat (4) @(posedge ref_clk);
   endtask

   // One control byte, start bit first, then optional clock ticks with data low.
   task automatic send(input logic [7:0] b, input int extra);
      @(posedge ref_clk);
      csPinN <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         dinPin <= b[i];
         half(1'b0);
         half(1'b1);
      end
      dinPin <= 1'b0;
      for (int i = 0; i < extra; i++) begin
         half(1'b0);
         half(1'b1);
      end
      half(1'b0);
      csPinN <= 1'b1;
      // A released data line shows no stale level.
      dinPin <= ~dinPin;
   endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import amc_pkg::*;

   localparam int CalCycles = 20;

   logic        ref_clk       = 1'b0;
   logic        sys_rst       = 1'b1;
   logic        hsel          = 1'b0;
   logic [31:0] haddr         = 32'h0;
   logic [1:0]  htrans        = 2'h0;
   logic        hwrite        = 1'b0;
   logic [2:0]  hsize         = 3'h2;
   logic [31:0] hwdata        = 32'h0;
   logic        rstPinN       = 1'b1;
   logic        powerDownPinN = 1'b1;
   logic [15:0] rawSample     = 16'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        sclkPin;
   logic        dinPin;
   logic        csPinN;
   logic        strobe;
   logic [15:0] resultWord;
   logic        lowPower;
   logic        irq;
   logic [31:0] rd;
   int          errorCnt       = 0;
   int          samplesChecked = 0;
   int          nS;
   int          nL;
   int          n;

   always #50 ref_clk = ~ref_clk;

   amc_host_model host (.ref_clk(ref_clk), .sclkPin(sclkPin), .dinPin(dinPin), .csPinN(csPinN));

   amc_ctrl #(.CAL_CYCLES(CalCycles)) DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sclkPin(sclkPin), .dinPin(dinPin),
      .csPinN(csPinN), .rstPinN(rstPinN), .powerDownPinN(powerDownPinN),
      .rawSample(rawSample), .conversionStrobeOut(strobe), .resultWord(resultWord),
      .lowPowerOut(lowPower), .irq(irq));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errorCnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Sends a byte and counts the cycles the strobe stays low.
   task automatic runConv(input logic [7:0] b, output int cnt);
      cnt = 0;
      fork
         host.send(b, 0);
         begin
            for (int i = 0; i < 200 && strobe !== 1'b0; i++) @(posedge ref_clk);
            while (strobe === 1'b0 && cnt < 400) begin
               @(posedge ref_clk);
               cnt++;
            end
         end
      join
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic t_reset;
      ahb(1'b0, 8'h00, 32'h0);
      check("ctrl", rd, 32'h1);
      ahb(1'b0, 8'h10, 32'h0);
      check("intmask", rd, 32'h0);
      ahb(1'b0, 8'h14, 32'h0);
      check("unmapped", rd, 32'h0);
      check("hresp", hresp, 32'h0);
      check("hreadyout", hreadyout, 32'h1);
      check("strobe idle", strobe, 32'h1);
      check("lowpower", lowPower, 32'h0);
   endtask

   task automatic t_short;
      ahb(1'b1, 8'h10, 32'h1);
      rawSample <= 16'h1234;
      runConv(8'hC0, nS);
      check("short length", nS, 32'd48);
      check("result uni", resultWord, 32'h1234);
      ahb(1'b0, 8'h04, 32'h0);
      check("status short", rd[4:3], 32'h2);
      check("irq set", irq, 32'h1);
      ahb(1'b1, 8'h0C, 32'hF);
      repeat (2) @(posedge ref_clk);
      check("irq clear", irq, 32'h0);
   endtask

   task automatic t_long;
      rawSample <= 16'h0001;
      runConv(8'h83, nL);
      check("result bip", resultWord, 32'h8001);
      check("long minus short", nL - nS, 32'd16);
   endtask

   task automatic t_pd;
      ahb(1'b1, 8'h0C, 32'hF);
      rawSample <= 16'h00F0;
      runConv(8'hC2, n);
      check("pd length", n, nL);
      check("pd lowpower", lowPower, 32'h1);
      check("pd result", resultWord, 32'h00F0);
      ahb(1'b0, 8'h0C, 32'h0);
      check("pd intstat", rd, 32'h9);
      ahb(1'b0, 8'h04, 32'h0);
      check("pd status", rd[3:0], 32'hC);
      host.send(8'hC0, 0);
      repeat (80) @(posedge ref_clk);
      check("wake", lowPower, 32'h0);
   endtask

   task automatic t_cal;
      ahb(1'b1, 8'h0C, 32'hF);
      runConv(8'h81, n);
      check("cal length", n - nS, 2 * (CalCycles - 24));
      ahb(1'b0, 8'h0C, 32'h0);
      check("cal done", rd, 32'h2);
      check("cal irq masked", irq, 32'h0);
   endtask

   task automatic t_abort;
      ahb(1'b1, 8'h0C, 32'hF);
      host.send(8'h81, 0);
      host.send(8'hC0, 0);
      repeat (80) @(posedge ref_clk);
      ahb(1'b0, 8'h0C, 32'h0);
      check("abort by start", rd[2], 32'h1);
      ahb(1'b1, 8'h0C, 32'hF);
      host.send(8'h81, 0);
      repeat (5) @(posedge ref_clk);
      powerDownPinN <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check("pin shutdown", lowPower, 32'h1);
      ahb(1'b0, 8'h0C, 32'h0);
      check("abort by pin", rd[2], 32'h1);
      powerDownPinN <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check("pin release", lowPower, 32'h0);
      host.send(8'h81, 0);
      repeat (5) @(posedge ref_clk);
      rstPinN <= 1'b0;
      repeat (6) @(posedge ref_clk);
      ahb(1'b0, 8'h04, 32'h0);
      check("abort by reset", rd[2:0], 32'h0);
      rstPinN <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask

   task automatic t_ext;
      ahb(1'b1, 8'h00, 32'h0);
      ahb(1'b1, 8'h0C, 32'hF);
      repeat (4) @(posedge ref_clk);
      check("ext idle strobe", strobe, 32'h0);
      // Calibration in external clock mode, counted on the extra serial clock ticks.
      fork
         host.send(8'h81, 40);
         begin
            for (int i = 0; i < 300 && strobe !== 1'b1; i++) @(posedge ref_clk);
            check("ext cal strobe", strobe, 32'h1);
         end
      join
      repeat (4) @(posedge ref_clk);
      check("ext end strobe", strobe, 32'h0);
      ahb(1'b0, 8'h0C, 32'h0);
      check("ext cal done", rd[1], 32'h1);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // The whole sequence needs well under 10000 cycles.
   initial begin
      repeat (20000) @(posedge ref_clk);
      errorCnt++;
      test_done();
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      t_reset();
      t_short();
      t_long();
      t_pd();
      t_cal();
      t_abort();
      t_ext();
      test_done();
   end
endmodule
`default_nettype wire
